// ---- shared/qdl_pkg.sv ----
package qdl_pkg;
    // ==========================================
    // Word layout
    localparam int QDL_WORD_BITS = 16;
    localparam int QDL_CODE_BITS = 8;
    localparam int QDL_NUM_CHAN = 4;
    localparam int QDL_FIFO_DEPTH = 8;
    localparam int QDL_SEL_HI = 15;
    localparam int QDL_SEL_LO = 14;
    localparam int QDL_SOFT_DOWN = 13;
    localparam int QDL_SPEED = 12;
    localparam int QDL_CODE_MSB = 11;
    localparam int QDL_CODE_LSB = 4;
    localparam int QDL_PAD_MSB = 3;
    localparam logic [4:0] QDL_BIT_ONE = 5'h01;
    localparam logic [4:0] QDL_BIT_LAST = 5'h0F;
    localparam logic [7:0] QDL_CODE_RST = 8'h00;

    // ==========================================
    // Timing
    localparam int QDL_CLK_MHZ = 100;
    localparam int QDL_FAST_NS = 2500;
    localparam int QDL_SLOW_NS = 8500;
    localparam int QDL_CNT_W = 10;
    localparam logic [QDL_CNT_W-1:0] QDL_FAST_CYC =
        QDL_CNT_W'((QDL_FAST_NS * QDL_CLK_MHZ + 999) / 1000);
    localparam logic [QDL_CNT_W-1:0] QDL_SLOW_CYC =
        QDL_CNT_W'((QDL_SLOW_NS * QDL_CLK_MHZ + 999) / 1000);
    localparam logic [QDL_CNT_W-1:0] QDL_CNT_ONE = 10'h001;

    // ==========================================
    // States
    typedef enum logic [1:0] {
        LK_IDLE = 2'h0,
        LK_SHIFT = 2'h1,
        LK_DONE = 2'h2
    } qdl_link_e;

    typedef enum logic {
        DR_IDLE = 1'h0,
        DR_SETTLE = 1'h1
    } qdl_drain_e;

    // ==========================================
    // Helpers
    function automatic logic [7:0] qdl_code_of(input logic [15:0] word);
        return word[QDL_CODE_MSB:QDL_CODE_LSB];
    endfunction : qdl_code_of

    function automatic logic [1:0] qdl_sel_of(input logic [15:0] word);
        return {word[QDL_SEL_HI], word[QDL_SEL_LO]};
    endfunction : qdl_sel_of
endpackage : qdl_pkg

// ---- rtl/qdl_fifo.sv ----
`timescale 1ns/10ps
module qdl_fifo
    import qdl_pkg::*;
#(
    parameter int WIDTH = QDL_WORD_BITS,
    parameter int DEPTH = QDL_FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } qdl_fifo_s;

    qdl_fifo_s st;
    qdl_fifo_s next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
        return (p == LAST) ? '0 : p + AW'(1);
    endfunction : wrap

    // ==========================================
    // Handshakes
    assign in_ready = (st.count != (AW+1)'(DEPTH));
    assign out_valid = (st.count != '0);
    assign out_data = mem[st.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // ==========================================
    // Pointers
    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.wr = wrap(st.wr);
        end
        if (pop)
        begin
            next_st.rd = wrap(st.rd);
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[st.wr] <= in_data;
        end
    end
endmodule : qdl_fifo

// ---- rtl/qdl_loader.sv ----
`timescale 1ns/10ps
// Contract
// - Reset clears every latch and control bit to zero before any word.
// - Bits are shifted only while the active-low chip select is low.
// - Frame sync falling starts a frame; bits taken MSB first on falling clock.
// - After sixteen bits or an early frame sync rise, word goes to its latch; a word arriving while the word buffer is full is dropped.
// - Word is handed on at the first rising clock after the sixteenth falling.
// - Chip select lets several devices share one host serial port.
// - Bit 15 address high, 14 address low, 13 power-down, 12 speed.
// - Bits 11 to 4 hold the code; bits 3 to 0 should be zero.
// - Address 00/01/10/11 loads channel A/B/C/D only.
// - Power-down disables all amplifiers of every channel.
// - Hardware power-down is active low; high keeps channels enabled.
module qdl_loader
    import qdl_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Serial link
    input wire logic shift_clk,
    input wire logic cs_n,
    input wire logic frame_sync,
    input wire logic serial_din,
    // Control pins
    input wire logic latch_update_n,
    input wire logic hw_power_down_n,
    // Converter outputs
    output logic [7:0] code_a,
    output logic [7:0] code_b,
    output logic [7:0] code_c,
    output logic [7:0] code_d,
    output logic amp_enable,
    output logic fast_settle,
    // Status
    output logic rx_ready,
    output logic format_err,
    output logic settle_busy
);
    // ==========================================
    // State types
    typedef struct packed {
        logic lrst_meta;
        logic lrst_n;
        qdl_link_e state;
        logic [4:0] cnt;
        logic [15:0] shreg;
        logic done;
    } qdl_lneg_s;

    typedef struct packed {
        logic [15:0] word;
        logic tog;
    } qdl_lpos_s;

    typedef struct packed {
        logic tog_meta;
        logic tog_sync;
        logic tog_seen;
        logic ld_meta;
        logic ld_sync;
        logic ld_prev;
        logic pwrdn_meta;
        logic pwrdn_sync;
        qdl_drain_e state;
        logic [QDL_CNT_W-1:0] settle;
        logic [3:0][7:0] in_code;
        logic [3:0][7:0] out_code;
        logic soft_down;
        logic fast;
        logic fmt_err;
        logic amp_en;
    } qdl_core_s;

    qdl_lneg_s ln;
    qdl_lneg_s next_ln;
    qdl_lpos_s lp;
    qdl_lpos_s next_lp;
    qdl_core_s c;
    qdl_core_s next_c;

    logic push;
    logic pop;
    logic ld_fall;
    logic f_valid;
    logic [15:0] f_data;
    logic [1:0] sel;

    // ==========================================
    // Link: shift on falling edge
    always_comb
    begin
        next_ln = ln;
        next_ln.lrst_meta = resetn;
        next_ln.lrst_n = ln.lrst_meta;
        next_ln.done = 1'b0;
        unique case (ln.state)
            LK_IDLE:
            begin
                if (!cs_n && !frame_sync)
                begin
                    next_ln.shreg = {ln.shreg[14:0], serial_din};
                    next_ln.cnt = QDL_BIT_ONE;
                    next_ln.state = LK_SHIFT;
                end
            end
            LK_SHIFT:
            begin
                if (cs_n)
                begin
                    next_ln.state = LK_DONE;
                end
                else if (frame_sync)
                begin
                    next_ln.done = 1'b1;
                    next_ln.state = LK_IDLE;
                end
                else
                begin
                    next_ln.shreg = {ln.shreg[14:0], serial_din};
                    next_ln.cnt = ln.cnt + QDL_BIT_ONE;
                    if (ln.cnt == QDL_BIT_LAST)
                    begin
                        next_ln.done = 1'b1;
                        next_ln.state = LK_DONE;
                    end
                end
            end
            LK_DONE:
            begin
                if (frame_sync)
                begin
                    next_ln.state = LK_IDLE;
                end
            end
            default:
            begin
                next_ln.state = LK_IDLE;
            end
        endcase
        if (!ln.lrst_n)
        begin
            next_ln.state = LK_IDLE;
            next_ln.cnt = '0;
            next_ln.shreg = '0;
            next_ln.done = 1'b0;
        end
    end

    always_ff @(negedge shift_clk)
    begin
        ln <= next_ln;
    end

    // ==========================================
    // Link: hand word on at rising edge
    always_comb
    begin
        next_lp = lp;
        if (ln.done)
        begin
            next_lp.word = ln.shreg;
            next_lp.tog = !lp.tog;
        end
        if (!ln.lrst_n)
        begin
            next_lp = '0;
        end
    end

    always_ff @(posedge shift_clk)
    begin
        lp <= next_lp;
    end

    // ==========================================
    // Word buffer
    assign push = c.tog_sync ^ c.tog_seen;
    assign pop = (c.state == DR_IDLE) && f_valid;
    assign ld_fall = c.ld_prev && !c.ld_sync;
    assign sel = qdl_sel_of(f_data);

    qdl_fifo #(
        .WIDTH(QDL_WORD_BITS),
        .DEPTH(QDL_FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .resetn(resetn),
        .in_valid(push),
        .in_ready(rx_ready),
        .in_data(lp.word),
        .out_valid(f_valid),
        .out_ready(c.state == DR_IDLE),
        .out_data(f_data)
    );

    // ==========================================
    // Core: latches, power and settling
    always_comb
    begin
        next_c = c;
        next_c.tog_meta = lp.tog;
        next_c.tog_sync = c.tog_meta;
        next_c.tog_seen = c.tog_sync;
        next_c.ld_meta = latch_update_n;
        next_c.ld_sync = c.ld_meta;
        next_c.ld_prev = c.ld_sync;
        next_c.pwrdn_meta = hw_power_down_n;
        next_c.pwrdn_sync = c.pwrdn_meta;
        if (ld_fall)
        begin
            next_c.out_code = c.in_code;
        end
        unique case (c.state)
            DR_IDLE:
            begin
                if (pop)
                begin
                    next_c.in_code[sel] = qdl_code_of(f_data);
                    next_c.out_code[sel] = qdl_code_of(f_data);
                    next_c.soft_down = f_data[QDL_SOFT_DOWN];
                    next_c.fast = f_data[QDL_SPEED];
                    next_c.fmt_err = |f_data[QDL_PAD_MSB:0];
                    next_c.settle = f_data[QDL_SPEED] ? QDL_FAST_CYC : QDL_SLOW_CYC;
                    next_c.state = DR_SETTLE;
                end
            end
            DR_SETTLE:
            begin
                next_c.settle = c.settle - QDL_CNT_ONE;
                if (c.settle == QDL_CNT_ONE)
                begin
                    next_c.state = DR_IDLE;
                end
            end
        endcase
        next_c.amp_en = !next_c.soft_down && c.pwrdn_sync;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            c <= '0;
        end
        else
        begin
            c <= next_c;
        end
    end

    // ==========================================
    // Outputs
    assign code_a = c.out_code[0];
    assign code_b = c.out_code[1];
    assign code_c = c.out_code[2];
    assign code_d = c.out_code[3];
    assign amp_enable = c.amp_en;
    assign fast_settle = c.fast;
    assign format_err = c.fmt_err;
    assign settle_busy = (c.state == DR_SETTLE);

    // ==========================================
    // Assertions
    a_reset_clears_all: assert property (@(posedge core_clk)
        !resetn |=> (code_a == QDL_CODE_RST) && (code_b == QDL_CODE_RST)
            && (code_c == QDL_CODE_RST) && (code_d == QDL_CODE_RST) && !amp_enable)
        else $error("outputs not cleared by reset");

    a_shift_needs_select: assert property (@(negedge shift_clk)
        disable iff (!ln.lrst_n)
        cs_n |=> (ln.state != LK_SHIFT) && !ln.done)
        else $error("shift while chip select high");

    a_msb_first_shift: assert property (@(negedge shift_clk)
        disable iff (!ln.lrst_n)
        (ln.state == LK_SHIFT && !cs_n && !frame_sync)
            |=> (ln.shreg[0] == $past(serial_din))
            && (ln.shreg[15:1] == $past(ln.shreg[14:0])))
        else $error("bit not shifted in msb first");

    a_sixteen_bits_done: assert property (@(negedge shift_clk)
        disable iff (!ln.lrst_n)
        (ln.state == LK_SHIFT && ln.cnt == QDL_BIT_LAST && !cs_n && !frame_sync)
            |=> ln.done && (ln.state == LK_DONE))
        else $error("word not completed at sixteenth bit");

    a_early_end_done: assert property (@(negedge shift_clk)
        disable iff (!ln.lrst_n)
        (ln.state == LK_SHIFT && !cs_n && frame_sync) |=> ln.done)
        else $error("early frame end not loaded");

    a_rise_handoff: assert property (@(posedge shift_clk)
        disable iff (!ln.lrst_n)
        ln.done |=> (lp.word == $past(ln.shreg)) && (lp.tog != $past(lp.tog)))
        else $error("word not handed on at rising edge");

    a_channel_load: assert property (@(posedge core_clk)
        disable iff (!resetn)
        pop |=> (c.out_code[$past(sel)] == $past(qdl_code_of(f_data)))
            && (c.in_code[$past(sel)] == $past(qdl_code_of(f_data))))
        else $error("addressed channel not loaded");

    a_other_chan_hold: assert property (@(posedge core_clk)
        disable iff (!resetn)
        (pop && !ld_fall) |=> (c.in_code[$past(sel) + 2'h1] == $past(c.in_code[sel + 2'h1])))
        else $error("unaddressed channel changed");

    a_hw_power_down: assert property (@(posedge core_clk)
        disable iff (!resetn)
        !c.pwrdn_sync |=> !amp_enable)
        else $error("amplifiers on during hardware power-down");

    a_soft_power_down: assert property (@(posedge core_clk)
        disable iff (!resetn)
        (pop && f_data[QDL_SOFT_DOWN]) |=> !amp_enable && c.soft_down)
        else $error("amplifiers on during soft power-down");

    a_fast_settle_time: assert property (@(posedge core_clk)
        disable iff (!resetn)
        (pop && f_data[QDL_SPEED]) |-> ##250 (c.state == DR_SETTLE) ##1 (c.state == DR_IDLE))
        else $error("fast settle wait wrong length");

    a_latch_update: assert property (@(posedge core_clk)
        disable iff (!resetn)
        (ld_fall && !pop) |=> (c.out_code == $past(c.in_code)))
        else $error("latch update did not copy values");

    c_full_frame: cover property (@(negedge shift_clk)
        ln.state == LK_SHIFT && ln.cnt == QDL_BIT_LAST && !frame_sync ##1 ln.done);

    c_early_frame: cover property (@(negedge shift_clk)
        ln.state == LK_SHIFT && frame_sync && !cs_n);

    c_buffer_full: cover property (@(posedge core_clk) disable iff (!resetn) !rx_ready);

    c_latch_update: cover property (@(posedge core_clk) disable iff (!resetn) ld_fall);
endmodule : qdl_loader

// ---- test/qdl_host_model.sv ----
`timescale 1ns/10ps
module qdl_host_model
(
    // Serial link
    output logic shift_clk,
    output logic cs_n,
    output logic frame_sync,
    output logic serial_din
);
    // ==========================================
    // Idle levels
    initial
    begin
        shift_clk = 1'b1;
        cs_n = 1'b1;
        frame_sync = 1'b1;
        serial_din = 1'b0;
    end

    // ==========================================
    // Clock pulses, 15 ns each, stopped high between calls
    task automatic pulse(input int n);
        repeat (n)
        begin
            #7.5 shift_clk = 1'b0;
            #7.5 shift_clk = 1'b1;
        end
    endtask : pulse

    // ==========================================
    // Frame: mode 0 normal, 1 never selected, 2 deselect mid-frame, 3 three-wire
    task automatic send(input logic [15:0] word, input int nbits, input int mode);
        int i;
        cs_n = (mode == 1);
        pulse(2);
        frame_sync = 1'b0;
        for (i = 15; i > 15 - nbits; i--)
        begin
            serial_din = word[i];
            if (mode == 2 && i == 7)
                cs_n = 1'b1;
            pulse(1);
            if (i == 8)
                #30;
        end
        frame_sync = 1'b1;
        serial_din = ~serial_din;
        pulse(2);
        cs_n = (mode != 3);
        #15;
    endtask : send
endmodule : qdl_host_model

// ---- test/quad_dac_serial_word_loader_tb.sv ----
`timescale 1ns/10ps
module quad_dac_serial_word_loader_tb
    import qdl_pkg::*;
;
    // ==========================================
    // Signals
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic latch_update_n = 1'b1;
    logic hw_power_down_n = 1'b1;
    logic shift_clk, cs_n, frame_sync, serial_din;
    logic [7:0] code_a, code_b, code_c, code_d;
    logic amp_enable, fast_settle, rx_ready, format_err, settle_busy;
    logic [7:0] exp_code [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    int failures = 0;
    int samples_checked = 0;

    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    qdl_host_model host_u (.shift_clk(shift_clk), .cs_n(cs_n), .frame_sync(frame_sync),
        .serial_din(serial_din));

    qdl_loader dut_u (.core_clk(core_clk), .resetn(resetn), .shift_clk(shift_clk),
        .cs_n(cs_n), .frame_sync(frame_sync), .serial_din(serial_din),
        .latch_update_n(latch_update_n), .hw_power_down_n(hw_power_down_n),
        .code_a(code_a), .code_b(code_b), .code_c(code_c), .code_d(code_d),
        .amp_enable(amp_enable), .fast_settle(fast_settle), .rx_ready(rx_ready),
        .format_err(format_err), .settle_busy(settle_busy));

    // ==========================================
    // Helpers
    function automatic logic [7:0] code_of(input int ch);
        case (ch)
            0: return code_a;
            1: return code_b;
            2: return code_c;
            default: return code_d;
        endcase
    endfunction : code_of

    function automatic logic [15:0] mk(input int ch, input logic down, input logic fast,
        input logic [7:0] code, input logic [3:0] low);
        return {2'(ch), down, fast, code, low};
    endfunction : mk

    task automatic report_and_stop();
        $display("failures=%0d checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic check_all();
        for (int i = 0; i < 4; i++)
            check(code_of(i), exp_code[i], "channel code");
    endtask : check_all

    task automatic wait_until(input int ch, input logic [7:0] exp, input bit idle);
        int n;
        n = 0;
        while (((idle && settle_busy !== 1'b0) || (!idle && code_of(ch) !== exp)) && n < 12000)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n == 12000)
        begin
            failures++;
            $display("BAD %0t wait ran out", $time);
            report_and_stop();
        end
    endtask : wait_until

    task automatic send_apply(input int ch, input logic down, input logic fast,
        input logic [7:0] code, input logic [3:0] low, input int mode);
        host_u.send(mk(ch, down, fast, code, low), 16, mode);
        exp_code[ch] = code;
        wait_until(ch, code, 1'b0);
        check_all();
    endtask : send_apply

    // ==========================================
    // Scenarios
    task automatic t_reset();
        check(code_a | code_b | code_c | code_d, 8'h00, "codes after reset");
        check({fast_settle, format_err, settle_busy}, 8'h00, "flags after reset");
        check(rx_ready, 8'h01, "buffer after reset");
        repeat (6) @(negedge core_clk);
        check(amp_enable, 8'h01, "amps on with pin high");
        $display("test reset done");
    endtask : t_reset

    task automatic t_channels();
        logic [7:0] tbl [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h01};
        for (int ch = 0; ch < 4; ch++)
            send_apply(ch, 1'b0, 1'b1, tbl[ch], 4'h0, 0);
        check(fast_settle, 8'h01, "fast settle");
        $display("test channels done");
    endtask : t_channels

    task automatic t_power();
        send_apply(2, 1'b1, 1'b0, 8'h40, 4'h0, 0);
        check(amp_enable, 8'h00, "soft power-down");
        check(fast_settle, 8'h00, "slow settle");
        send_apply(2, 1'b0, 1'b1, 8'h41, 4'h0, 0);
        check(amp_enable, 8'h01, "power up");
        hw_power_down_n = 1'b0;
        repeat (5) @(negedge core_clk);
        check(amp_enable, 8'h00, "pin power-down");
        hw_power_down_n = 1'b1;
        repeat (5) @(negedge core_clk);
        check(amp_enable, 8'h01, "pin released");
        $display("test power done");
    endtask : t_power

    task automatic t_format();
        send_apply(1, 1'b0, 1'b1, 8'h77, 4'h9, 0);
        check(format_err, 8'h01, "low bits set");
        send_apply(1, 1'b0, 1'b1, 8'h78, 4'h0, 0);
        check(format_err, 8'h00, "low bits clear");
        $display("test format done");
    endtask : t_format

    task automatic t_select();
        wait_until(0, 8'h00, 1'b1);
        host_u.send(mk(0, 1'b0, 1'b1, 8'h99, 4'h0), 16, 1);
        repeat (400) @(negedge core_clk);
        check(code_a, exp_code[0], "not selected");
        host_u.send(mk(0, 1'b0, 1'b1, 8'h98, 4'h0), 16, 2);
        repeat (400) @(negedge core_clk);
        check(code_a, exp_code[0], "deselected mid-frame");
        send_apply(0, 1'b0, 1'b1, 8'h9A, 4'h0, 3);
        send_apply(3, 1'b0, 1'b1, 8'h9B, 4'h0, 3);
        $display("test select done");
    endtask : t_select

    task automatic t_early();
        send_apply(3, 1'b0, 1'b1, 8'h12, 4'h0, 0);
        host_u.send(16'h5A0F, 12, 0);
        exp_code[0] = 8'h5A;
        wait_until(0, 8'h5A, 1'b0);
        check_all();
        $display("test early end done");
    endtask : t_early

    task automatic t_fifo();
        wait_until(0, 8'h00, 1'b1);
        for (int i = 0; i < 9; i++)
            host_u.send(mk(1, 1'b0, 1'b0, 8'(8'h10 + i), 4'h0), 16, 0);
        repeat (4) @(negedge core_clk);
        check(rx_ready, 8'h00, "buffer full");
        host_u.send(mk(1, 1'b0, 1'b0, 8'h33, 4'h0), 16, 0);
        exp_code[1] = 8'h18;
        wait_until(1, 8'h18, 1'b0);
        repeat (900) @(negedge core_clk);
        check_all();
        check({rx_ready, settle_busy, fast_settle}, 8'h04, "drained");
        $display("test buffer done");
    endtask : t_fifo

    task automatic t_latch();
        latch_update_n = 1'b0;
        repeat (6) @(negedge core_clk);
        latch_update_n = 1'b1;
        repeat (6) @(negedge core_clk);
        check_all();
        $display("test latch update done");
    endtask : t_latch

    // ==========================================
    // Main sequence
    initial
    begin
        fork
            begin
                repeat (4) @(negedge core_clk);
                resetn = 1'b1;
            end
            host_u.pulse(3);
        join
        host_u.pulse(3);
        @(negedge core_clk);
        t_reset();
        t_channels();
        t_power();
        t_format();
        t_select();
        t_early();
        t_fifo();
        t_latch();
        report_and_stop();
    end
endmodule : quad_dac_serial_word_loader_tb
